/* lmcd_decoder.sv */
/*
  command decoder of a stepper positioner: quick status response, safe position, halt and position zeroing.
  assumes a frame layer that checks identifier parity and checksum, presents writing frames of the
  general two-data-byte pointer as one-cycle pulses, and raises status_req on this node's direct identifier.
  assumes a position controller that owns the actual position and reports motor_moving.
  assumes event inputs are single-cycle pulses; a held level acts again on every clock.
  assumes node_address, safe_position and temp_info are steady levels.
  limitations the user must know:
    status flags clear when the response is captured, not when its last byte leaves the node.
    a set event in the capture cycle survives the clear and shows in the next response.
    zeroing is ignored while a halt waits for the motor to come to rest.
    safe moves run only from the run state; internal ones are held until then.
    internal safe moves that arrive in shutdown are dropped, not held.
    sleep_ready stays set until reset once the pre-sleep safe move has been issued.
*/
// Function
// RQ1 - answering a quick status query clears the six listed status flags
// RQ2 - an electrical defect caused only by an open coil clears on quick query
// RQ3 - an electrical defect caused by a shorted coil clears only on full query
// RQ4 - quick status answered in frame with two data bytes and checksum
// RQ5 - response bytes carry switch, address, then flags and temperature bits
// RQ6 - master fills the identifier parity bits
// RQ7 - master gives each node its own quick status identifier
// RQ8 - command 0x04 drives the motor to the stored safe position
// RQ9 - lost bus, end of init and sleep entry trigger the safe move internally
// RQ10 - these commands are decoded from the data bytes alone
// RQ11 - safe position command with broadcast bit zero applies to every node
// RQ12 - a coil problem triggers an internal halt and enters shutdown
// RQ13 - internal halt during motion sets the missed step flag
// RQ14 - once halted, actual position is copied into target position
// RQ15 - command 0x05 halts the motor; broadcast bit zero halts every node
// RQ16 - zeroing clears actual and target position
// RQ17 - zeroing sets the reference done flag
// RQ18 - zeroing with broadcast bit zero applies to every node
// RQ19 - master sends marker bit, code, broadcast bit and address, then checksum
// RQ20 - with broadcast bit one, only a matching node address executes
`timescale 1ns/100ps
`include "lmcd_defines.svh"

module lmcd_decoder #(
  parameter int POS_W = `LMCD_POS_W,
  parameter int SAFE_W = `LMCD_SAFE_POS_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`LMCD_ADDR_W-1:0] node_address,
  input wire logic motion_switch_state,
  input wire logic [1:0] temp_info,
  input wire logic wr_valid,
  input wire lmcd_pkg::lmcd_wr_frame_type wr_frame,
  input wire logic status_req,
  input wire logic full_status_query,
  input wire logic thermal_warning_evt,
  input wire logic thermal_shutdown_evt,
  input wire logic undervoltage_evt,
  input wire logic supply_reset_evt,
  input wire logic stall_evt,
  input wire logic open_coil_evt,
  input wire logic short_coil_evt,
  input wire logic comm_lost,
  input wire logic init_done,
  input wire logic sleep_req,
  input wire logic motor_moving,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic [SAFE_W-1:0] safe_position,
  output logic resp_valid,
  output lmcd_pkg::lmcd_status_resp_type resp_data,
  output logic [POS_W-1:0] target_position,
  output logic target_load,
  output logic halt_motor,
  output logic zero_actual,
  output logic reference_done,
  output logic shutdown,
  output logic sleep_ready
);

  // all state of the decoder except the status flags, which lmcd_status_flags holds
  typedef struct packed {
    lmcd_pkg::lmcd_state_type fsm;
    logic resp_valid;
    lmcd_pkg::lmcd_status_resp_type resp;
    logic [POS_W-1:0] target;
    logic target_load;
    logic halt_motor;
    logic zero_actual;
    logic reference_done;
    logic shutdown;
    logic safe_pending;
    logic sleep_pending;
    logic sleep_ready;
    logic coil_halt_shutdown;
  } lmcd_dec_state_type;

  lmcd_dec_state_type state;
  lmcd_dec_state_type next_state;

  lmcd_pkg::lmcd_flags_type flags;
  lmcd_pkg::lmcd_flag_evt_type flag_evt;
  lmcd_pkg::lmcd_src_type src;
  logic coil_fault;
  logic master_halt;
  logic master_zero;
  logic master_safe;
  logic internal_trigger;
  logic motion_allowed;
  logic [POS_W-1:0] safe_target;
  logic at_rest;
  logic defect_clear;
  logic sleep_issue;
  logic halt_while_moving;

  // true when the frame is a writing frame carrying the given code
  function automatic logic is_cmd(input lmcd_pkg::lmcd_wr_frame_type f, input logic [6:0] code);
    is_cmd = f.cmd_byte[`LMCD_WR_MARK_BIT] && (f.cmd_byte[6:0] == code); // RQ10 RQ19
  endfunction

  // true when the frame is meant for this node
  function automatic logic addressed(input lmcd_pkg::lmcd_wr_frame_type f,
                                     input logic [`LMCD_ADDR_W-1:0] addr);
    addressed = (f.addr_byte[`LMCD_BROAD_BIT] == `LMCD_BROAD_ALL) // RQ11 RQ15 RQ18
                || (f.addr_byte[6:0] == addr); // RQ20
  endfunction

  // first response byte: switch state above the node address
  function automatic logic [7:0] status_byte1(input logic sw, input logic [`LMCD_ADDR_W-1:0] addr);
    status_byte1 = {sw, addr}; // RQ5
  endfunction

  // second response byte: flags from supply reset down to thermal warning, then temperature
  function automatic logic [7:0] status_byte2(input lmcd_pkg::lmcd_flags_type f, input logic [1:0] temp);
    status_byte2 = {f.supply_reset_flag,
                    f.missed_step_flag,
                    f.eldef_open | f.eldef_short,
                    f.undervoltage_flag,
                    f.thermal_shutdown_flag,
                    f.thermal_warning_flag,
                    temp}; // RQ5
  endfunction

  // master commands, decoded only from the data bytes
  assign master_halt = wr_valid && is_cmd(wr_frame, `LMCD_CMD_HALT)
                       && addressed(wr_frame, node_address); // RQ15
  assign master_zero = wr_valid && is_cmd(wr_frame, `LMCD_CMD_ZERO)
                       && addressed(wr_frame, node_address); // RQ16
  assign master_safe = wr_valid && is_cmd(wr_frame, `LMCD_CMD_GO_SAFE)
                       && addressed(wr_frame, node_address); // RQ8

  // coil trouble of either kind halts the motor
  assign coil_fault = open_coil_evt || short_coil_evt; // RQ12

  // internal safe move requests, held outside shutdown until arbitration takes them
  assign internal_trigger = comm_lost || init_done || sleep_req; // RQ9

  // safe position widened to the target width
  assign safe_target = {{(POS_W-SAFE_W){1'b0}}, safe_position};

  // safe moves, master and internal, run only from the run state
  assign motion_allowed = (state.fsm == lmcd_pkg::lmcd_st_run);

  // an internal halt while the motor turns may have lost steps
  assign halt_while_moving = coil_fault && motor_moving; // RQ13

  // a waiting halt completes once the motor rests and no new halt arrives
  assign at_rest = !motor_moving
                   && (src != lmcd_pkg::lmcd_src_coil_halt)
                   && (src != lmcd_pkg::lmcd_src_master_halt);

  // shutdown may end only when no defect flag or new coil fault remains
  assign defect_clear = !flags.eldef_open && !flags.eldef_short && !coil_fault;

  // the internal safe move that runs now also completes a pending sleep entry
  assign sleep_issue = state.sleep_pending || sleep_req;

  // command priority: halts first, then zeroing, then master safe move, then internal safe move
  always_comb begin
    src = lmcd_pkg::lmcd_src_none;
    if (coil_fault) begin
      src = lmcd_pkg::lmcd_src_coil_halt; // RQ12
    end else if (master_halt) begin
      src = lmcd_pkg::lmcd_src_master_halt;
    end else if (master_zero && state.fsm != lmcd_pkg::lmcd_st_halt_wait) begin
      src = lmcd_pkg::lmcd_src_master_zero;
    end else if (master_safe && motion_allowed) begin
      src = lmcd_pkg::lmcd_src_master_safe;
    end else if ((state.safe_pending || internal_trigger) && motion_allowed) begin
      src = lmcd_pkg::lmcd_src_internal_safe; // RQ9
    end
  end

  // flag set events; an internal halt during motion marks possible step loss
  always_comb begin
    flag_evt = '0;
    flag_evt.thermal_warning = thermal_warning_evt;
    flag_evt.thermal_shutdown = thermal_shutdown_evt;
    flag_evt.undervoltage = undervoltage_evt;
    flag_evt.supply_reset = supply_reset_evt;
    flag_evt.open_coil = open_coil_evt;
    flag_evt.short_coil = short_coil_evt;
    flag_evt.missed_step = stall_evt || halt_while_moving; // RQ13
  end

  // sticky flags with quick and full clearing
  lmcd_status_flags lmcd_status_flags_i (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(flag_evt),
    .quick_clear(status_req), // RQ1
    .full_clear(full_status_query), // RQ3
    .flags(flags)
  );

  // next state of the decoder
  always_comb begin
    next_state = state;
    // pulses fall back to zero unless a command raises them
    next_state.resp_valid = 1'b0;
    next_state.target_load = 1'b0;
    next_state.halt_motor = 1'b0;
    next_state.zero_actual = 1'b0;

    // quick status response built from the flags before they are cleared
    if (status_req) begin
      next_state.resp_valid = 1'b1; // RQ4
      next_state.resp.data1 = status_byte1(motion_switch_state, node_address); // RQ5
      next_state.resp.data2 = status_byte2(flags, temp_info); // RQ5
    end

    // remember internal triggers that could not run yet
    if (internal_trigger) begin
      next_state.safe_pending = 1'b1; // RQ9
    end
    // a sleep request also waits for its safe move
    if (sleep_req) begin
      next_state.sleep_pending = 1'b1;
    end

    // execute the winning command
    case (src)
      lmcd_pkg::lmcd_src_coil_halt: begin
        // stop at once and hold off motion until the defect is gone
        next_state.halt_motor = 1'b1; // RQ12
        next_state.shutdown = 1'b1; // RQ12
        next_state.coil_halt_shutdown = 1'b1;
        next_state.fsm = lmcd_pkg::lmcd_st_halt_wait;
      end
      lmcd_pkg::lmcd_src_master_halt: begin
        // stop at once; motion resumes once the motor rests
        next_state.halt_motor = 1'b1; // RQ15
        next_state.fsm = lmcd_pkg::lmcd_st_halt_wait;
      end
      lmcd_pkg::lmcd_src_master_zero: begin
        // controller clears the actual position on the pulse
        next_state.target = '0; // RQ16
        next_state.zero_actual = 1'b1; // RQ16
        next_state.reference_done = 1'b1; // RQ17
      end
      lmcd_pkg::lmcd_src_master_safe: begin
        // drive to the stored safe position
        next_state.target = safe_target; // RQ8
        next_state.target_load = 1'b1; // RQ8
      end
      lmcd_pkg::lmcd_src_internal_safe: begin
        // consume the pending request with the move
        next_state.target = safe_target; // RQ9
        next_state.target_load = 1'b1; // RQ9
        next_state.safe_pending = 1'b0;
        if (sleep_issue) begin
          next_state.sleep_ready = 1'b1;
          next_state.sleep_pending = 1'b0;
        end
      end
      default: begin
        // no command this cycle
      end
    endcase

    // state sequencing
    case (state.fsm)
      lmcd_pkg::lmcd_st_run: begin
        // nothing to sequence; commands were taken above
      end
      lmcd_pkg::lmcd_st_halt_wait: begin
        // keep the stop position once the motor is at rest
        if (at_rest) begin
          next_state.target = actual_position; // RQ14
          next_state.fsm = state.coil_halt_shutdown ? lmcd_pkg::lmcd_st_shutdown : lmcd_pkg::lmcd_st_run;
        end
      end
      lmcd_pkg::lmcd_st_shutdown: begin
        // leave shutdown once no defect flag remains
        if (defect_clear) begin
          next_state.shutdown = 1'b0;
          next_state.coil_halt_shutdown = 1'b0;
          next_state.fsm = lmcd_pkg::lmcd_st_run;
        end
      end
      default: begin
        // an unused state code falls back to run
        next_state.fsm = lmcd_pkg::lmcd_st_run;
      end
    endcase

    // internal safe moves are dropped while in shutdown
    if (state.fsm == lmcd_pkg::lmcd_st_shutdown) begin
      next_state.safe_pending = 1'b0;
    end
  end

  // decoder register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // every field to its idle value
      state.fsm <= lmcd_pkg::lmcd_st_run;
      state.resp_valid <= `LMCD_RST_FLAG;
      state.resp.data1 <= `LMCD_RST_BYTE;
      state.resp.data2 <= `LMCD_RST_BYTE;
      state.target <= '0;
      state.target_load <= `LMCD_RST_FLAG;
      state.halt_motor <= `LMCD_RST_FLAG;
      state.zero_actual <= `LMCD_RST_FLAG;
      state.reference_done <= `LMCD_RST_FLAG;
      state.shutdown <= `LMCD_RST_FLAG;
      state.safe_pending <= `LMCD_RST_FLAG;
      state.sleep_pending <= `LMCD_RST_FLAG;
      state.sleep_ready <= `LMCD_RST_FLAG;
      state.coil_halt_shutdown <= `LMCD_RST_FLAG;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the register
  assign resp_valid = state.resp_valid;
  assign resp_data = state.resp;
  assign target_position = state.target;
  assign target_load = state.target_load;
  assign halt_motor = state.halt_motor;
  assign zero_actual = state.zero_actual;
  assign reference_done = state.reference_done;
  assign shutdown = state.shutdown;
  assign sleep_ready = state.sleep_ready;

endmodule // lmcd_decoder

/* lmcd_defines.svh */
/*
  shared constants of the command decoder: command codes, frame bit positions, widths and reset values.
  assumes it is included by bare name from the package and the design modules.
*/
`ifndef LMCD_DEFINES_SVH
`define LMCD_DEFINES_SVH

// command codes carried in the low seven bits of the first data byte
`define LMCD_CMD_GO_SAFE 7'h04
`define LMCD_CMD_HALT 7'h05
`define LMCD_CMD_ZERO 7'h06

// frame bit positions
`define LMCD_WR_MARK_BIT 7
`define LMCD_BROAD_BIT 7
`define LMCD_BROAD_ALL 1'b0

// widths
`define LMCD_SAFE_POS_W 11
`define LMCD_POS_W 16
`define LMCD_ADDR_W 7

// reset values
`define LMCD_RST_BYTE 8'h00
`define LMCD_RST_FLAG 1'b0

`endif

/* lmcd_pkg.sv */
/*
  types of the command decoder: frame carriers, status response, flag sets and controller states.
  assumes lmcd_defines.svh is on the include path.
*/
`include "lmcd_defines.svh"

package lmcd_pkg;

  // two data bytes of a writing frame whose checksum the frame layer has already checked
  typedef struct packed {
    logic [7:0] cmd_byte;
    logic [7:0] addr_byte;
  } lmcd_wr_frame_type;

  // two data bytes of the quick status response, first byte sent first
  typedef struct packed {
    logic [7:0] data1;
    logic [7:0] data2;
  } lmcd_status_resp_type;

  // sticky status flags; electrical defect is split by its cause
  typedef struct packed {
    logic supply_reset_flag;
    logic missed_step_flag;
    logic eldef_open;
    logic eldef_short;
    logic undervoltage_flag;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
  } lmcd_flags_type;

  // one-cycle flag set events
  typedef struct packed {
    logic supply_reset;
    logic missed_step;
    logic open_coil;
    logic short_coil;
    logic undervoltage;
    logic thermal_shutdown;
    logic thermal_warning;
  } lmcd_flag_evt_type;

  // motion command state
  typedef enum logic [1:0] {
    lmcd_st_run,
    lmcd_st_halt_wait,
    lmcd_st_shutdown
  } lmcd_state_type;

  // winner of the command arbitration, highest first
  typedef enum logic [2:0] {
    lmcd_src_none,
    lmcd_src_coil_halt,
    lmcd_src_master_halt,
    lmcd_src_master_zero,
    lmcd_src_master_safe,
    lmcd_src_internal_safe
  } lmcd_src_type;

endpackage

/* lmcd_status_flags.sv */
/*
  sticky status flags of the positioner with quick and full clearing.
  assumes one-cycle set events and clear pulses synchronous to clk.
*/
`timescale 1ns/100ps
`include "lmcd_defines.svh"

module lmcd_status_flags (
  input wire logic clk,
  input wire logic arst_n,
  input wire lmcd_pkg::lmcd_flag_evt_type set_evt,
  input wire logic quick_clear,
  input wire logic full_clear,
  output lmcd_pkg::lmcd_flags_type flags
);

  lmcd_pkg::lmcd_flags_type state;
  lmcd_pkg::lmcd_flags_type next_state;

  // a set in the clear cycle wins over the clear
  always_comb begin
    next_state = state;
    if (quick_clear || full_clear) begin
      next_state.thermal_warning_flag = 1'b0; // RQ1
      next_state.thermal_shutdown_flag = 1'b0; // RQ1
      next_state.undervoltage_flag = 1'b0; // RQ1
      next_state.missed_step_flag = 1'b0; // RQ1
      next_state.supply_reset_flag = 1'b0; // RQ1
      next_state.eldef_open = 1'b0; // RQ2
    end
    if (full_clear) begin
      next_state.eldef_short = 1'b0; // RQ3
    end
    if (set_evt.thermal_warning) next_state.thermal_warning_flag = 1'b1;
    if (set_evt.thermal_shutdown) next_state.thermal_shutdown_flag = 1'b1;
    if (set_evt.undervoltage) next_state.undervoltage_flag = 1'b1;
    if (set_evt.missed_step) next_state.missed_step_flag = 1'b1;
    if (set_evt.supply_reset) next_state.supply_reset_flag = 1'b1;
    if (set_evt.open_coil) next_state.eldef_open = 1'b1;
    if (set_evt.short_coil) next_state.eldef_short = 1'b1;
  end

  // flag register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state;

endmodule // lmcd_status_flags

/* lmcd_decoder_assertions.sv */
/*
  concurrent checks on the ports of the command decoder.
  assumes it is bound into every lmcd_decoder instance and sees clk and arst_n there.
*/
`timescale 1ns/100ps
`include "lmcd_defines.svh"

module lmcd_decoder_checker #(
  parameter int POS_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`LMCD_ADDR_W-1:0] node_address,
  input wire logic motion_switch_state,
  input wire logic wr_valid,
  input wire lmcd_pkg::lmcd_wr_frame_type wr_frame,
  input wire logic status_req,
  input wire logic open_coil_evt,
  input wire logic short_coil_evt,
  input wire logic resp_valid,
  input wire lmcd_pkg::lmcd_status_resp_type resp_data,
  input wire logic [POS_W-1:0] target_position,
  input wire logic halt_motor,
  input wire logic zero_actual,
  input wire logic reference_done,
  input wire logic shutdown
);
  logic addr_ok;
  logic coil;
  // frame meant for this node, and a competing coil fault
  assign addr_ok = !wr_frame.addr_byte[7] || wr_frame.addr_byte[6:0] == node_address;
  assign coil = open_coil_evt || short_coil_evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_resp_pulse; status_req |=> resp_valid; endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("status response missing");
  property p_resp_byte1; status_req |=> resp_data.data1 == {$past(motion_switch_state), $past(node_address)}; endproperty
  a_resp_byte1: assert property (p_resp_byte1) else $error("status byte one wrong");
  property p_zero_regs; zero_actual |-> target_position == '0 && reference_done; endproperty
  a_zero_regs: assert property (p_zero_regs) else $error("zeroing left target or reference");
  property p_ref_sticky; reference_done |=> reference_done; endproperty
  a_ref_sticky: assert property (p_ref_sticky) else $error("reference done dropped");
  property p_coil; coil |=> halt_motor && shutdown; endproperty
  a_coil: assert property (p_coil) else $error("coil fault without halt and shutdown");
  property p_halt;
    wr_valid && wr_frame.cmd_byte == {1'b1, `LMCD_CMD_HALT} && addr_ok && !shutdown |=> halt_motor;
  endproperty
  a_halt: assert property (p_halt) else $error("halt frame not obeyed");
  property p_foreign;
    wr_valid && wr_frame.addr_byte[7] && wr_frame.addr_byte[6:0] != node_address && !coil
      |=> !halt_motor && !zero_actual;
  endproperty
  a_foreign: assert property (p_foreign) else $error("frame for another node obeyed");
  property p_marker; wr_valid && !wr_frame.cmd_byte[7] && !coil |=> !halt_motor && !zero_actual; endproperty
  a_marker: assert property (p_marker) else $error("frame without marker obeyed");

  // main scenarios reached
  c_resp: cover property (status_req ##1 resp_valid);
  c_zero: cover property (zero_actual);
  c_coil: cover property (halt_motor && shutdown);
endmodule // lmcd_decoder_checker

bind lmcd_decoder lmcd_decoder_checker #(.POS_W(POS_W)) lmcd_decoder_checker_i (.clk, .arst_n, .node_address,
  .motion_switch_state, .wr_valid, .wr_frame, .status_req, .open_coil_evt, .short_coil_evt, .resp_valid,
  .resp_data, .target_position, .halt_motor, .zero_actual, .reference_done, .shutdown);

/* lmcd_master_model.sv */
/*
  behavioural bus master facing the decoder: writing frames and quick status polls.
  assumes the frame layer in between has checked identifier parity and checksum.
*/
`timescale 1ns/100ps

module lmcd_master_model (
  input wire logic clk,
  output logic wr_valid,
  output lmcd_pkg::lmcd_wr_frame_type wr_frame,
  output logic status_req
);
  // quiet bus at time zero
  initial begin
    wr_valid = 1'b0;
    wr_frame = 16'h0000;
    status_req = 1'b0;
  end

  // one two-byte writing frame on the general pointer
  task automatic write_frame(input logic [7:0] cmd, input logic [7:0] addr);
    @(negedge clk);
    wr_frame = {cmd, addr};
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_frame = ~wr_frame; // released data never repeats
  endtask

  // header on this node's own status identifier
  task automatic poll_status();
    @(negedge clk);
    status_req = 1'b1;
    @(negedge clk);
    status_req = 1'b0;
  endtask
endmodule // lmcd_master_model

/* lin_motion_command_decoder_tb.sv */
/*
  self-checking bench of the command decoder: status polls, writing frames, coil faults, internal triggers.
  assumes lmcd_master_model stands for the bus master and the bench plays the position controller.
*/
`timescale 1ns/100ps

module lin_motion_command_decoder_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] node_address = 7'h2a;
  logic motion_switch_state = 1'b1;
  logic [1:0] temp_info = 2'b10;
  logic [10:0] ev = 11'h000;
  logic motor_moving = 1'b0;
  logic [15:0] actual_position = 16'h0123;
  logic [10:0] safe_position = 11'h5a3;
  logic wr_valid, status_req, resp_valid, target_load, halt_motor, zero_actual;
  logic reference_done, shutdown, sleep_ready;
  lmcd_pkg::lmcd_wr_frame_type wr_frame;
  lmcd_pkg::lmcd_status_resp_type resp_data;
  logic [15:0] target_position;
  int num_errors = 0;
  int num_checks = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  lmcd_master_model lmcd_master_model_i (.clk, .wr_valid, .wr_frame, .status_req);
  lmcd_decoder lmcd_decoder_i (.clk, .arst_n, .node_address, .motion_switch_state, .temp_info, .wr_valid,
    .wr_frame, .status_req, .full_status_query(ev[3]), .thermal_warning_evt(ev[10]),
    .thermal_shutdown_evt(ev[9]), .undervoltage_evt(ev[8]), .supply_reset_evt(ev[7]), .stall_evt(ev[6]),
    .open_coil_evt(ev[5]), .short_coil_evt(ev[4]), .comm_lost(ev[2]), .init_done(ev[1]), .sleep_req(ev[0]),
    .motor_moving, .actual_position, .safe_position, .resp_valid, .resp_data, .target_position, .target_load,
    .halt_motor, .zero_actual, .reference_done, .shutdown, .sleep_ready);

  // verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // compare of any port value
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one-cycle pulse on the event inputs
  task automatic pulse(input logic [10:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 11'h000;
  endtask

  // quick status poll with expected second byte
  task automatic status(input logic [7:0] exp2);
    lmcd_master_model_i.poll_status();
    check(resp_valid, 16'h0001);
    check(resp_data.data1, {motion_switch_state, node_address});
    check(resp_data.data2, exp2);
  endtask

  // writing frame and the three command pulses that follow it
  task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [2:0] exp);
    lmcd_master_model_i.write_frame(c, a);
    check({zero_actual, halt_motor, target_load}, exp);
  endtask

  // bounded wait for the end of shutdown
  task automatic wait_run();
    for (int i = 0; i < 20; i++) begin
      if (shutdown === 1'b0) begin
        repeat (3) @(negedge clk);
        return;
      end
      @(negedge clk);
    end
    num_errors++;
    $display("unexpected at %0t: shutdown never ended", $time);
    report_and_stop();
  endtask

  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    check(reference_done, 16'h0000);
    pulse(11'h7c0);
    status(8'hde);
    status(8'h02);
    cmd(8'h06, 8'h2a, 3'b000);
    cmd(8'h86, 8'h95, 3'b000);
    cmd(8'h87, 8'h2a, 3'b000);
    actual_position = 16'h0777;
    cmd(8'h86, 8'haa, 3'b100);
    check(target_position, 16'h0000);
    check(reference_done, 16'h0001);
    cmd(8'h86, 8'h15, 3'b100);
    cmd(8'h84, 8'h15, 3'b001);
    check(target_position, {5'h00, safe_position});
    cmd(8'h85, 8'h15, 3'b010);
    repeat (3) @(negedge clk);
    check(target_position, actual_position);
    for (int i = 0; i < 3; i++) begin
      safe_position = 11'h100 + 11'(i);
      pulse(11'h001 << i);
      check(target_load, 16'h0001);
      check(target_position, {5'h00, safe_position});
    end
    check(sleep_ready, 16'h0001);
    actual_position = 16'h0321;
    motor_moving = 1'b1;
    pulse(11'h020);
    check({halt_motor, shutdown}, 16'h0003);
    motor_moving = 1'b0;
    status(8'h62);
    status(8'h02);
    wait_run();
    check(target_position, actual_position);
    pulse(11'h010);
    status(8'h22);
    cmd(8'h84, 8'h15, 3'b000);
    status(8'h22);
    pulse(11'h008);
    status(8'h02);
    wait_run();
    report_and_stop();
  end
endmodule // lin_motion_command_decoder_tb
